// ==== src/multi_bus_dma_controller.v ====
/*
  Eight-channel DMA controller mastering three buses, with an APB register
  slave and a bridge from the interconnect bus to the private bus.
  Assumes all buses share clk; bus slaves hold busAck high for one cycle.
*/
// Function
// RULE1 - Eight independent channels, each with its own register set.
// RULE2 - A started channel reads source and writes destination without the processor.
// RULE3 - Transfers run within any of three buses or between any pair.
// RULE4 - Interconnect requests bridge onto the private bus; controller alone masters it.
// RULE5 - Each channel picks its hardware trigger from eight request inputs.
// RULE6 - Each channel takes one of two priority levels.
// RULE7 - Start by software request or by the selected hardware request line.
// RULE8 - Single mode clears the enable after the programmed transfers.
// RULE9 - Continuous mode stays enabled after the programmed transfers.
// RULE10 - Full 32-bit source and destination addresses with programmable modification.
// RULE11 - Circular addressing wraps inside a bounded buffer region.
// RULE12 - Transfer width is 8, 16 or 32 bits.
// RULE13 - At least one move is buffered between read and write.
// RULE14 - Registers per channel: source, destination, control/status, count.
// RULE15 - Bus priority of the controller is programmable per bus.
// RULE16 - Every attached bus runs on the same clock.
// RULE17 - Service requests per channel and for serial link channels.
// RULE18 - Count drops per transfer; zero marks completion and may request service.
// RULE19 - Higher level wins; ties go to the lowest channel number.
`include "dma_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module multi_bus_dma_controller #(
  parameter LINKS = 4,
  parameter FIFO_AW = 1
) (
  input wire clk, // see RULE16
  input wire reset,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] hwReq,
  input wire [LINKS-1:0] linkEvent,
  output wire [7:0] chanSrq,
  output wire [LINKS-1:0] linkSrq,
  output reg [5:0] busPriority,
  output wire [2:0] busReq,
  output wire [2:0] busWrite,
  output wire [95:0] busAddr,
  output wire [95:0] busWdata,
  output wire [5:0] busSize,
  input wire [95:0] busRdata,
  input wire [2:0] busAck,
  input wire bridgeReq,
  input wire bridgeWrite,
  input wire [31:0] bridgeAddr,
  input wire [31:0] bridgeWdata,
  output reg bridgeAck,
  output reg [31:0] bridgeRdata
);
  localparam DEPTH = 1 << FIFO_AW;
  localparam FW = 68;
  reg [31:0] srcAddr [0:7];
  reg [31:0] dstAddr [0:7];
  reg [26:0] ctrl [0:7];
  reg [31:0] cnt [0:7];
  reg [7:0] hwMeta;
  reg [7:0] hwSync;
  reg [LINKS-1:0] linkFlag;
  reg [LINKS-1:0] linkMask;
  reg [1:0] rdState;
  reg [2:0] rdCh;
  reg [1:0] rdBus;
  reg [31:0] rdData;
  reg [FW-1:0] fifoMem [0:DEPTH-1];
  reg [FIFO_AW-1:0] fifoWp;
  reg [FIFO_AW-1:0] fifoRp;
  reg [FIFO_AW:0] fifoCount;
  reg [31:0] readMux;
  wire [7:0] chanReq;
  wire [7:0] chanHigh;
  wire [3:0] pick;
  wire [2:0] rdWant;
  wire [2:0] wrWant;
  wire [2:0] rdDone;
  wire [2:0] wrDone;
  wire [2:0] brDone;
  wire fifoInValid;
  wire fifoInReady;
  wire fifoOutValid;
  wire fifoOutReady;
  wire [FW-1:0] fifoIn;
  wire [FW-1:0] fifoHead;
  wire pushDone;
  wire apbHit;
  wire apbWr;
  integer ch;
  function [1:0] busClamp;
    input [1:0] sel;
    begin
      busClamp = (sel > `BUS_LINK) ? `BUS_LINK : sel;
    end
  endfunction
  // Lowest set index of the high level, else of all requests
  function [3:0] pickChan;
    input [7:0] reqs;
    input [7:0] high;
    integer i;
    reg [7:0] sel;
    begin
      sel = ((reqs & high) != 8'h00) ? (reqs & high) : reqs; // see RULE6
      pickChan = 4'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (sel[i]) begin
          pickChan = {1'b1, i[2:0]}; // see RULE19
        end
      end
    end
  endfunction
  // Width 3 is reserved and steps like 64 bits
  function [31:0] nextAddr;
    input [31:0] addr;
    input [1:0] mode;
    input [1:0] width;
    input circ;
    input [4:0] csize;
    reg [31:0] step;
    reg [31:0] moved;
    reg [31:0] mask;
    begin
      step = 32'h0000_0001 << width; // see RULE12
      if (mode == `MOD_INC) begin
        moved = addr + step; // see RULE10
      end else if (mode == `MOD_DEC) begin
        moved = addr - step;
      end else begin
        moved = addr;
      end
      mask = (32'h0000_0001 << csize) - 32'h0000_0001;
      nextAddr = circ ? ((addr & ~mask) | (moved & mask)) : moved; // see RULE11
    end
  endfunction
  always @(posedge clk) begin
    if (reset) begin
      hwMeta <= 8'h00;
      hwSync <= 8'h00;
    end else begin
      hwMeta <= hwReq;
      hwSync <= hwMeta;
    end
  end
  genvar c;
  generate
    for (c = 0; c < 8; c = c + 1) begin : chanGen
      assign chanReq[c] = ctrl[c][`CTRL_EN] && (cnt[c][`CNT_LEFT] != `CNT_ZERO) &&
        (ctrl[c][`CTRL_SWREQ] || (ctrl[c][`CTRL_HWEN] && hwSync[ctrl[c][`CTRL_SEL]])); // see RULE7 see RULE5
      assign chanHigh[c] = ctrl[c][`CTRL_PRIO];
      assign chanSrq[c] = ctrl[c][`CTRL_DONE] && ctrl[c][`CTRL_SRE]; // see RULE17
    end
  endgenerate
  assign pick = pickChan(chanReq, chanHigh);
  // APB slave; read data is latched in the setup cycle
  assign apbHit = (paddr[1:0] == 2'h0) && (paddr <= `OFF_CHANDONE);
  assign pready = psel && penable;
  assign pslverr = pready && !apbHit;
  assign apbWr = pready && pwrite && apbHit;
  always @* begin
    readMux = `ZERO32;
    if (paddr[7] == 1'b0) begin
      if (paddr[3:0] == `OFF_SRC) begin
        readMux = srcAddr[paddr[6:4]];
      end else if (paddr[3:0] == `OFF_DST) begin
        readMux = dstAddr[paddr[6:4]];
      end else if (paddr[3:0] == `OFF_CTRL) begin
        readMux = {4'h0, (rdState != `RD_IDLE) && (rdCh == paddr[6:4]), ctrl[paddr[6:4]]};
      end else begin
        readMux = cnt[paddr[6:4]];
      end
    end else if (paddr == `OFF_BUSPRIO) begin
      readMux = {26'h0, busPriority};
    end else if (paddr == `OFF_LINKFLAG) begin
      readMux[LINKS-1:0] = linkFlag;
    end else if (paddr == `OFF_LINKMASK) begin
      readMux[LINKS-1:0] = linkMask;
    end else if (paddr == `OFF_CHANDONE) begin
      readMux = {24'h0, ctrl[7][`CTRL_DONE], ctrl[6][`CTRL_DONE], ctrl[5][`CTRL_DONE],
        ctrl[4][`CTRL_DONE], ctrl[3][`CTRL_DONE], ctrl[2][`CTRL_DONE],
        ctrl[1][`CTRL_DONE], ctrl[0][`CTRL_DONE]};
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      prdata <= `ZERO32;
    end else if (psel && !penable && !pwrite) begin
      prdata <= apbHit ? readMux : `ZERO32;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      busPriority <= 6'h00;
      linkMask <= {LINKS{1'b0}};
      linkFlag <= {LINKS{1'b0}};
    end else begin
      if (apbWr && paddr == `OFF_BUSPRIO) begin
        busPriority <= pwdata[5:0]; // see RULE15
      end
      if (apbWr && paddr == `OFF_LINKMASK) begin
        linkMask <= pwdata[LINKS-1:0];
      end
      // New events win over a write-one-to-clear in the same cycle
      if (apbWr && paddr == `OFF_LINKFLAG) begin
        linkFlag <= (linkFlag & ~pwdata[LINKS-1:0]) | linkEvent; // see RULE17
      end else begin
        linkFlag <= linkFlag | linkEvent;
      end
    end
  end
  assign linkSrq = linkFlag & linkMask;
  // Channel registers; engine updates follow APB writes so a done set wins
  always @(posedge clk) begin
    if (reset) begin
      for (ch = 0; ch < 8; ch = ch + 1) begin
        srcAddr[ch] <= `ZERO32;
        dstAddr[ch] <= `ZERO32;
        ctrl[ch] <= 27'h0;
        cnt[ch] <= `ZERO32;
      end
    end else begin
      for (ch = 0; ch < 8; ch = ch + 1) begin
        if (apbWr && paddr[7] == 1'b0 && paddr[6:4] == ch) begin // see RULE14
          if (paddr[3:0] == `OFF_SRC) begin
            srcAddr[ch] <= pwdata;
          end else if (paddr[3:0] == `OFF_DST) begin
            dstAddr[ch] <= pwdata;
          end else if (paddr[3:0] == `OFF_CTRL) begin
            ctrl[ch][`CTRL_CFG] <= pwdata[`CTRL_CFG];
            if (pwdata[`CTRL_SWREQ]) begin
              ctrl[ch][`CTRL_SWREQ] <= 1'b1; // see RULE7
            end
            if (pwdata[`CTRL_DONE]) begin
              ctrl[ch][`CTRL_DONE] <= 1'b0;
            end
          end else begin
            cnt[ch] <= {pwdata[`CNT_RELOAD], pwdata[`CNT_RELOAD]};
          end
        end
        if (pushDone && rdCh == ch) begin
          srcAddr[ch] <= nextAddr(srcAddr[ch], ctrl[ch][`CTRL_SMOD], ctrl[ch][`CTRL_WIDTH],
            ctrl[ch][`CTRL_SCIRC], ctrl[ch][`CTRL_CSIZE]);
          dstAddr[ch] <= nextAddr(dstAddr[ch], ctrl[ch][`CTRL_DMOD], ctrl[ch][`CTRL_WIDTH],
            ctrl[ch][`CTRL_DCIRC], ctrl[ch][`CTRL_CSIZE]);
          if (cnt[ch][`CNT_LEFT] == `CNT_ONE) begin
            ctrl[ch][`CTRL_DONE] <= 1'b1; // see RULE18
            ctrl[ch][`CTRL_SWREQ] <= 1'b0;
            if (ctrl[ch][`CTRL_CONT]) begin
              cnt[ch][`CNT_LEFT] <= cnt[ch][`CNT_RELOAD]; // see RULE9
            end else begin
              cnt[ch][`CNT_LEFT] <= `CNT_ZERO;
              ctrl[ch][`CTRL_EN] <= 1'b0; // see RULE8
            end
          end else begin
            cnt[ch][`CNT_LEFT] <= cnt[ch][`CNT_LEFT] - `CNT_ONE; // see RULE18
          end
        end
      end
    end
  end
  // Read side: one channel at a time fetches one item into the buffer
  always @(posedge clk) begin
    if (reset) begin
      rdState <= `RD_IDLE;
      rdCh <= 3'h0;
      rdBus <= 2'h0;
      rdData <= `ZERO32;
    end else begin
      case (rdState)
        `RD_IDLE: begin
          if (pick[3]) begin
            rdCh <= pick[2:0]; // see RULE1
            rdBus <= busClamp(ctrl[pick[2:0]][`CTRL_SBUS]); // see RULE3
            rdState <= `RD_BUS;
          end
        end
        `RD_BUS: begin
          if (rdDone != 3'h0) begin
            rdData <= busRdata[{rdBus, 5'h00} +: 32]; // see RULE2
            rdState <= `RD_PUSH;
          end
        end
        `RD_PUSH: begin
          if (fifoInReady) begin
            rdState <= `RD_IDLE;
          end
        end
        default: begin
          rdState <= `RD_IDLE;
        end
      endcase
    end
  end
  assign fifoInValid = (rdState == `RD_PUSH);
  assign pushDone = fifoInValid && fifoInReady;
  assign fifoIn = {busClamp(ctrl[rdCh][`CTRL_DBUS]), ctrl[rdCh][`CTRL_WIDTH],
    dstAddr[rdCh], rdData};
  // Two-entry move buffer decouples each read from its write
  assign fifoInReady = (fifoCount != DEPTH[FIFO_AW:0]); // see RULE13
  assign fifoOutValid = (fifoCount != {(FIFO_AW + 1){1'b0}});
  assign fifoHead = fifoMem[fifoRp];
  assign fifoOutReady = (wrDone != 3'h0);
  always @(posedge clk) begin
    if (reset) begin
      fifoWp <= {FIFO_AW{1'b0}};
      fifoRp <= {FIFO_AW{1'b0}};
      fifoCount <= {(FIFO_AW + 1){1'b0}};
    end else begin
      if (pushDone) begin
        fifoMem[fifoWp] <= fifoIn;
        fifoWp <= fifoWp + 1'b1;
      end
      if (fifoOutValid && fifoOutReady) begin
        fifoRp <= fifoRp + 1'b1;
      end
      if (pushDone && !(fifoOutValid && fifoOutReady)) begin
        fifoCount <= fifoCount + 1'b1;
      end else if (!pushDone && fifoOutValid && fifoOutReady) begin
        fifoCount <= fifoCount - 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      bridgeAck <= 1'b0;
      bridgeRdata <= `ZERO32;
    end else begin
      bridgeAck <= (brDone != 3'h0); // see RULE4
      if (brDone != 3'h0) begin
        bridgeRdata <= busRdata[32*`BUS_PRIVATE +: 32];
      end
    end
  end

  // One master port per bus; the owner holds the request until busAck
  genvar b;
  generate
    for (b = 0; b < 3; b = b + 1) begin : busGen
      reg [1:0] owner;
      reg [31:0] addrR;
      reg [31:0] dataR;
      reg writeR;
      reg [1:0] sizeR;
      wire brWant;
      assign brWant = (b == `BUS_PRIVATE) && bridgeReq && !bridgeAck; // see RULE4
      assign rdWant[b] = (rdState == `RD_BUS) && (rdBus == b);
      assign wrWant[b] = fifoOutValid && (fifoHead[67:66] == b);
      assign rdDone[b] = busAck[b] && (owner == `OWN_RD);
      assign wrDone[b] = busAck[b] && (owner == `OWN_WR);
      assign brDone[b] = busAck[b] && (owner == `OWN_BRIDGE);
      assign busReq[b] = (owner != `OWN_NONE);
      assign busWrite[b] = writeR;
      assign busAddr[32*b +: 32] = addrR;
      assign busWdata[32*b +: 32] = dataR;
      assign busSize[2*b +: 2] = sizeR;
      always @(posedge clk) begin
        if (reset) begin
          owner <= `OWN_NONE;
          addrR <= `ZERO32;
          dataR <= `ZERO32;
          writeR <= 1'b0;
          sizeR <= 2'h0;
        end else if (owner != `OWN_NONE) begin
          if (busAck[b]) begin
            owner <= `OWN_NONE;
          end
        end else if (brWant) begin
          owner <= `OWN_BRIDGE;
          addrR <= bridgeAddr;
          dataR <= bridgeWdata;
          writeR <= bridgeWrite;
          sizeR <= `WIDTH_32;
        end else if (wrWant[b]) begin
          owner <= `OWN_WR; // see RULE2
          addrR <= fifoHead[63:32];
          dataR <= fifoHead[31:0];
          writeR <= 1'b1;
          sizeR <= fifoHead[65:64]; // see RULE12
        end else if (rdWant[b]) begin
          owner <= `OWN_RD;
          addrR <= srcAddr[rdCh];
          writeR <= 1'b0;
          sizeR <= ctrl[rdCh][`CTRL_WIDTH];
        end
      end
    end
  endgenerate
endmodule // multi_bus_dma_controller
`default_nettype wire

// ==== pkg/dma_defines.vh ====
/*
  Register map, field positions and codes of the DMA controller.
  Assumes inclusion by the controller file only.
*/
`ifndef DMA_DEFINES_VH
`define DMA_DEFINES_VH
`define OFF_SRC 4'h0
`define OFF_DST 4'h4
`define OFF_CTRL 4'h8
`define OFF_CNT 4'hc
`define OFF_BUSPRIO 8'h80
`define OFF_LINKFLAG 8'h84
`define OFF_LINKMASK 8'h88
`define OFF_CHANDONE 8'h8c
`define CTRL_EN 0
`define CTRL_CONT 1
`define CTRL_HWEN 2
`define CTRL_SEL 5:3
`define CTRL_PRIO 6
`define CTRL_WIDTH 8:7
`define CTRL_SBUS 10:9
`define CTRL_DBUS 12:11
`define CTRL_SMOD 14:13
`define CTRL_DMOD 16:15
`define CTRL_SCIRC 17
`define CTRL_DCIRC 18
`define CTRL_CSIZE 23:19
`define CTRL_SRE 24
`define CTRL_CFG 24:0
`define CTRL_SWREQ 25
`define CTRL_DONE 26
`define CNT_RELOAD 15:0
`define CNT_LEFT 31:16
`define CNT_ONE 16'h0001
`define CNT_ZERO 16'h0000
`define MOD_INC 2'h1
`define MOD_DEC 2'h2
`define WIDTH_32 2'h2
`define BUS_PRIVATE 1
`define BUS_LINK 2'h2
`define OWN_NONE 2'h0
`define OWN_RD 2'h1
`define OWN_WR 2'h2
`define OWN_BRIDGE 2'h3
`define RD_IDLE 2'h0
`define RD_BUS 2'h1
`define RD_PUSH 2'h2
`define ZERO32 32'h0000_0000
`endif

// ==== tb/multi_bus_dma_checker.sv ====
/* Port checker of the DMA controller.
   Bound to the top module; one clock, synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module multi_bus_dma_checker (
  input wire clk,
  input wire reset,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [2:0] busReq,
  input wire [2:0] busWrite,
  input wire [95:0] busAddr,
  input wire [2:0] busAck,
  input wire bridgeAck
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_apb_ready: assert property (
    psel && penable |-> pready) else $error("no ready in access");
  chk_apb_idle: assert property (
    !psel |-> !pready && !pslverr) else $error("ready while idle");
  chk_apb_unmapped: assert property (
    psel && penable && (paddr > 8'h8c || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  chk_read_hold: assert property (
    busReq[0] && !busAck[0] |=> busReq[0] && $stable(busAddr[31:0]) && $stable(busWrite[0]))
    else $error("bus 0 request dropped early");
  chk_read_gap: assert property (
    busReq[0] && busAck[0] |=> !busReq[0]) else $error("bus 0 no idle cycle");
  chk_link_gap: assert property (
    busReq[2] && busAck[2] |=> !busReq[2]) else $error("bus 2 no idle cycle");
  chk_private_hold: assert property (
    busReq[1] && !busAck[1] |=> busReq[1] && $stable(busAddr[63:32]))
    else $error("bus 1 request dropped early");
  chk_bridge_ack: assert property (
    bridgeAck |-> $past(busAck[1]) ##1 !bridgeAck) else $error("bridge ack misplaced");
  chk_reset_quiet: assert property (
    $fell(reset) |-> busReq == 3'h0 && !bridgeAck) else $error("busy after reset");
endmodule // multi_bus_dma_checker
`default_nettype wire

// ==== tb/bus_slave_model.sv ====
/* Slave model of the three buses, answering 1 to 3 cycles after a request.
   Assumes busReq and its fields hold until busAck. */
`timescale 1ns/1ns
`default_nettype none
module bus_slave_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] busReq,
  input wire logic [95:0] busAddr,
  output logic [95:0] busRdata,
  output logic [2:0] busAck
);
  int unsigned delay [3];
  // Same clock as the controller; read data is a pattern of the address
  always @(posedge clk) begin
    for (int b = 0; b < 3; b++) begin
      if (reset) begin
        busAck[b] <= 1'b0;
        delay[b] <= 0;
        busRdata[32*b +: 32] <= 32'h0000_0000;
      end else if (busReq[b] && !busAck[b] && delay[b] == 0) begin
        busAck[b] <= 1'b1;
        busRdata[32*b +: 32] <= busAddr[32*b +: 32] ^ 32'hc3c3_0000;
        delay[b] <= $urandom_range(3);
      end else begin
        busAck[b] <= 1'b0;
        // Released data never repeats its last value
        busRdata[32*b +: 32] <= ~busRdata[32*b +: 32];
        if (busReq[b] && delay[b] != 0)
          delay[b] <= delay[b] - 1;
      end
    end
  end
endmodule // bus_slave_model
`default_nettype wire

// ==== tb/multi_bus_dma_controller_test.sv ====
/* Bench of the DMA controller: APB master, bridge requester, request lines.
   Assumes the slave model and checker files are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module multi_bus_dma_controller_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] hwReq = 8'h00;
  logic [3:0] linkEvent = 4'h0;
  logic bridgeReq = 1'b0;
  logic bridgeWrite = 1'b0;
  logic [31:0] bridgeAddr = 32'h0000_0000;
  logic [31:0] bridgeWdata = 32'h0000_0000;
  logic [31:0] prdata, bridgeRdata, base;
  logic pready, pslverr, bridgeAck;
  logic [7:0] chanSrq;
  logic [3:0] linkSrq;
  logic [5:0] busPriority, busSize, prio;
  logic [2:0] busReq, busWrite, busAck;
  logic [95:0] busAddr, busWdata, busRdata;
  logic [32:0] rdExp [$];
  logic [67:0] wrExp [$];
  logic [31:0] brExp [$];
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  multi_bus_dma_controller #(.LINKS(4), .FIFO_AW(1)) multi_bus_dma_controller_inst (
    .clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hwReq(hwReq), .linkEvent(linkEvent), .chanSrq(chanSrq), .linkSrq(linkSrq),
    .busPriority(busPriority), .busReq(busReq), .busWrite(busWrite), .busAddr(busAddr),
    .busWdata(busWdata), .busSize(busSize), .busRdata(busRdata), .busAck(busAck),
    .bridgeReq(bridgeReq), .bridgeWrite(bridgeWrite), .bridgeAddr(bridgeAddr),
    .bridgeWdata(bridgeWdata), .bridgeAck(bridgeAck), .bridgeRdata(bridgeRdata));

  bus_slave_model bus_slave_model_inst (.clk(clk), .reset(reset), .busReq(busReq),
    .busAddr(busAddr), .busRdata(busRdata), .busAck(busAck));

  function automatic logic [31:0] pat(input logic [31:0] a);
    return a ^ 32'hc3c3_0000;
  endfunction

  task automatic check(input string what, input logic [67:0] seen, input logic [67:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rdExp.push_back(e);
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  task automatic prog(input int ch, input logic [31:0] s, d, n, k);
    apb(8'(ch * 16), 1'b1, s);
    apb(8'(ch * 16 + 4), 1'b1, d);
    apb(8'(ch * 16 + 12), 1'b1, n);
    apb(8'(ch * 16 + 8), 1'b1, k);
  endtask

  task automatic bridge(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    bridgeReq <= 1'b1;
    bridgeWrite <= w;
    bridgeAddr <= a;
    bridgeWdata <= d;
    do @(posedge clk); while (bridgeAck !== 1'b1);
    bridgeReq <= 1'b0;
    bridgeAddr <= ~a;
    bridgeWdata <= ~d;
  endtask

  task automatic drain;
    while (wrExp.size() > 0 || brExp.size() > 0)
      @(posedge clk);
    repeat (4) @(posedge clk);
  endtask

  // Results are taken off the queues in the order they appear
  always @(posedge clk) begin
    cycles++;
    if (psel && penable && !pwrite && rdExp.size() > 0)
      check("apb read", {35'h0, pslverr, prdata}, {35'h0, rdExp.pop_front()});
    for (int b = 0; b < 3; b++)
      if (busReq[b] && busAck[b] && busWrite[b])
        check("bus write", {2'(b), busSize[2*b +: 2], busAddr[32*b +: 32], busWdata[32*b +: 32]},
          wrExp.size() > 0 ? wrExp.pop_front() : '1);
    if (bridgeAck && brExp.size() > 0)
      check("bridge read", {36'h0, bridgeRdata}, {36'h0, brExp.pop_front()});
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    void'($urandom(11));
    base = $urandom & 32'hffff_fff0;
    prio = 6'($urandom);
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(8'h08, 33'h0);
    rd(8'h90, {1'b1, 32'h0});
    rd(8'h0a, {1'b1, 32'h0});
    for (int c = 0; c < 8; c++) apb(8'(c * 16), 1'b1, 32'hf000_0000 + c);
    for (int c = 0; c < 8; c++) rd(8'(c * 16), {1'b0, 32'hf000_0000 + c});
    $display("test registers done");
    wrExp.push_back({2'h2, 2'h2, 32'h200, pat(base)});
    wrExp.push_back({2'h2, 2'h2, 32'h204, pat(base + 4)});
    prog(0, base, 32'h200, 32'h0002_0002, 32'h0300_b101);
    drain();
    rd(8'h08, {1'b0, 32'h0500_b100});
    rd(8'h0c, {1'b0, 32'h0000_0002});
    rd(8'h8c, {1'b0, 32'h0000_0001});
    @(negedge clk);
    check("chan srq", chanSrq, 8'h01);
    apb(8'h08, 1'b1, 32'h0400_0000);
    @(negedge clk);
    check("chan srq clear", chanSrq, 8'h00);
    $display("test single mode done");
    wrExp.push_back({2'h1, 2'h2, 32'h500, pat(32'h400)});
    prog(1, 32'h400, 32'h500, 32'h0001_0001, 32'h0201_4d03);
    drain();
    rd(8'h18, {1'b0, 32'h0401_4d03});
    rd(8'h10, {1'b0, 32'h0000_03fc});
    apb(8'h18, 1'b1, 32'h0400_0000);
    $display("test continuous mode done");
    wrExp.push_back({2'h0, 2'h2, 32'h700, pat(32'h20)});
    wrExp.push_back({2'h0, 2'h1, 32'h600, pat(32'h10)});
    prog(2, 32'h10, 32'h600, 32'h0001_0001, 32'h0000_00ad);
    prog(3, 32'h20, 32'h700, 32'h0001_0001, 32'h0000_016d);
    hwReq <= 8'h20 | (8'($urandom) & 8'h80);
    drain();
    hwReq <= 8'h00;
    $display("test hardware priority done");
    for (int i = 0; i < 3; i++)
      wrExp.push_back({2'h0, 2'h2, 32'h300, pat(i == 1 ? 32'h200 : 32'h204)});
    brExp.push_back(pat(32'h904));
    fork
      prog(4, 32'h204, 32'h300, 32'h0003_0003, 32'h021a_2301);
      bridge(1'b0, 32'h904, 32'h0);
    join
    drain();
    wrExp.push_back({2'h1, 2'h2, 32'h908, base});
    bridge(1'b1, 32'h908, base);
    drain();
    // Byte moves into a two-byte circular destination
    wrExp.push_back({2'h0, 2'h0, 32'h43, pat(32'h31)});
    wrExp.push_back({2'h0, 2'h0, 32'h42, pat(32'h32)});
    prog(5, 32'h31, 32'h43, 32'h0002_0002, 32'h020c_a001);
    drain();
    $display("test circular and bridge done");
    apb(8'h80, 1'b1, {26'h0, prio});
    rd(8'h80, {27'h0, prio});
    @(negedge clk);
    check("bus priority", busPriority, prio);
    apb(8'h88, 1'b1, 32'h1);
    linkEvent <= 4'($urandom) | 4'h1;
    @(posedge clk);
    linkEvent <= 4'h0;
    repeat (2) @(negedge clk);
    check("link srq", linkSrq, 4'h1);
    apb(8'h84, 1'b1, 32'hf);
    @(negedge clk);
    check("link srq clear", linkSrq, 4'h0);
    $display("test global registers done");
    conclude();
  end
endmodule // multi_bus_dma_controller_test
bind multi_bus_dma_controller multi_bus_dma_checker multi_bus_dma_checker_inst (.clk(clk),
  .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .busReq(busReq), .busWrite(busWrite), .busAddr(busAddr),
  .busAck(busAck), .bridgeAck(bridgeAck));
`default_nettype wire
